//--- shared/mdsa_defs.svh
/*
 * Register indices, field positions, reset values and latency counts of the
 * arithmetic accelerator. Assumes inclusion by the design, the checker and the testbench.
 */
// Behaviour
// - All operands unsigned; 16-bit multiply, 32-bit divide, shift and normalize.
// - No busy flag; software waits a fixed number of cycles or polls IRQ status bit 0.
// - Latency counts from the clock edge of the final loading write.
// - 32/16 divide done within 17 cycles; 16/16 divide within 9.
// - 16x16 multiply gives 32-bit product within 10 cycles.
// - Normalize takes 3 to 19 cycles, shift 3 to 18 cycles.
// - Six byte data registers carry operands and results; one control register.
// - Error flag bit 7 sets when a data register is written while busy.
// - Reading the control register clears the error flag.
// - Overflow flag bit 6 sets when the product exceeds 0x0000ffff.
// - Direction bit 5: one shifts right, zero shifts left.
// - Shift count zero written selects normalization of the 32-bit operand.
// - After normalization the count field holds the leading-zero count.
// - Nonzero shift count shifts the operand that many places.
// - Division: data 0 write resets and arms errors; last write starts.
// - Normalize and shift start on control write after loading data 0 to 3.
// - Overflow also on zero divisor and on normalizing with top bit set.
`ifndef MDSA_DEFS_SVH
`define MDSA_DEFS_SVH

`define MDSA_IDX_DATA0   10'h0f9
`define MDSA_IDX_DATA1   10'h0fa
`define MDSA_IDX_DATA2   10'h0fb
`define MDSA_IDX_DATA3   10'h0fc
`define MDSA_IDX_DATA4   10'h0fd
`define MDSA_IDX_DATA5   10'h0fe
`define MDSA_IDX_CTRL    10'h0ff
`define MDSA_IDX_IRQ_STS 10'h100
`define MDSA_IDX_IRQ_CLR 10'h101
`define MDSA_IDX_IRQ_EN  10'h102

`define MDSA_CTRL_ERR    7
`define MDSA_CTRL_OVF    6
`define MDSA_CTRL_DIR    5
`define MDSA_DATA_RST    8'h00
`define MDSA_MUL_LIMIT   32'h0000ffff

`define MDSA_IRQ_DONE    0
`define MDSA_IRQ_ERR     1
`define MDSA_IRQ_OVF     2

`define MDSA_LAT_DIV32   5'h11
`define MDSA_LAT_DIV16   5'h09
`define MDSA_LAT_MUL     5'h0a
`define MDSA_LAT_SHIFT   5'h02
`define MDSA_LAT_NORM    5'h03

`endif

//--- shared/mdsa_pkg.sv
/*
 * Types of the arithmetic accelerator: APB request carrier, operation kinds
 * and the whole-module state record. Assumes mdsa_defs.svh on the include path.
 */
package mdsa_pkg;

  typedef enum logic [2:0] {
    MDSA_OP_NONE  = 3'b000,
    MDSA_OP_DIV32 = 3'b001,
    MDSA_OP_DIV16 = 3'b010,
    MDSA_OP_MUL   = 3'b011,
    MDSA_OP_NORM  = 3'b100,
    MDSA_OP_SHIFT = 3'b101
  } mdsa_op_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mdsa_apb_req_s;

  typedef struct packed {
    logic [5:0][7:0] data;
    logic [5:0][7:0] res;
    logic [4:0]      res_sc;
    logic            res_ovf;
    logic            dir;
    logic [4:0]      sc;
    logic            err;
    logic            ovf;
    logic            busy;
    logic [4:0]      cnt;
    mdsa_op_e        op;
    logic [5:0]      seen;
    logic            last_was_1;
    logic [2:0]      irq_sts;
    logic [2:0]      irq_en;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            irq;
  } mdsa_state_s;

endpackage

//--- hdl/mdsa_accel.sv
/*
 * Unsigned multiply, divide, shift and normalize accelerator behind an APB
 * slave. Each access takes one wait state. Assumes a single clock pclk and an
 * APB master that holds its request until pready.
 */
// The APB register port was decided locally.
`include "mdsa_defs.svh"

module mdsa_accel (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire mdsa_pkg::mdsa_apb_req_s apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq
);

  mdsa_pkg::mdsa_state_s s;
  mdsa_pkg::mdsa_state_s next_s;

  function automatic logic [4:0] mdsa_lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       hit;
    n   = 5'h1f;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n   = 5'(31 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  logic [9:0]      idx;
  logic            setup;
  logic            access;
  logic            wr;
  logic            rd;
  logic            mapped;
  logic [5:0]      wr_data;
  logic [5:0][7:0] wd;
  logic [31:0]     opa;
  logic [15:0]     opb;
  logic [15:0]     opa16;
  logic [31:0]     quo;
  logic [15:0]     rem;
  logic [15:0]     quo16;
  logic [15:0]     rem16;
  logic [31:0]     prod;
  logic [4:0]      lz;
  logic [4:0]      cnt_w;
  logic            start_div32;
  logic            start_div16;
  logic            start_mul;
  logic            start_ctrl;
  logic            set_err;
  logic            done;
  logic [2:0]      ev;
  logic [31:0]     rdata;

  always_comb begin
    idx    = apb_req.paddr[11:2];
    setup  = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable && s.pready;
    wr     = access && apb_req.pwrite;
    rd     = access && !apb_req.pwrite;
    mapped = (idx >= `MDSA_IDX_DATA0) && (idx <= `MDSA_IDX_IRQ_EN);
    for (int k = 0; k < 6; k++) begin
      wr_data[k] = wr && (idx == `MDSA_IDX_DATA0 + 10'(k));
    end
    wd = s.data;
    for (int k = 0; k < 6; k++) begin
      if (wr_data[k]) begin
        wd[k] = apb_req.pwdata[7:0];
      end
    end
    opa   = {wd[3], wd[2], wd[1], wd[0]};
    opb   = {wd[5], wd[4]};
    opa16 = {wd[1], wd[0]};
    quo   = (opb == 16'h0000) ? 32'hffffffff : opa / {16'h0000, opb};
    rem   = (opb == 16'h0000) ? opa[15:0] : 16'(opa % {16'h0000, opb});
    quo16 = (opb == 16'h0000) ? 16'hffff : opa16 / opb;
    rem16 = (opb == 16'h0000) ? opa16 : opa16 % opb;
    prod  = {16'h0000, opa16} * {16'h0000, opb};
    lz    = mdsa_lead_zeros(opa);
    cnt_w = apb_req.pwdata[4:0];
  end

  // Sequence recognition; data 5 completes division or multiply
  always_comb begin
    start_div32 = wr_data[5] && s.seen[0] && s.seen[1] && s.seen[2] && s.seen[3]
                  && s.seen[4];
    start_div16 = wr_data[5] && s.seen[0] && s.seen[1] && s.seen[4] && !s.seen[2]
                  && !s.seen[3] && !s.last_was_1;
    start_mul   = wr_data[5] && s.seen[0] && s.seen[1] && s.seen[4] && !s.seen[2]
                  && !s.seen[3] && s.last_was_1;
    start_ctrl  = wr && (idx == `MDSA_IDX_CTRL);
    set_err     = (|wr_data) && s.busy;
    done        = s.busy && (s.cnt == 5'h01);
  end

  always_comb begin
    rdata = 32'h0000_0000;
    for (int k = 0; k < 6; k++) begin
      if (idx == `MDSA_IDX_DATA0 + 10'(k)) begin
        rdata[7:0] = s.data[k];
      end
    end
    case (idx)
      `MDSA_IDX_CTRL:    rdata[7:0] = {s.err, s.ovf, s.dir, s.sc};
      `MDSA_IDX_IRQ_STS: rdata[2:0] = s.irq_sts;
      `MDSA_IDX_IRQ_EN:  rdata[2:0] = s.irq_en;
      default:           rdata = rdata;
    endcase
  end

  always_comb begin
    next_s = s;
    ev     = 3'b000;

    // APB slave: one wait state, answer registered in the setup cycle
    next_s.pready  = setup;
    next_s.prdata  = setup && !apb_req.pwrite ? rdata : 32'h0000_0000;
    next_s.pslverr = setup && !mapped;

    if (wr_data[1]) begin
      next_s.last_was_1 = 1'b1;
    end
    if (wr_data[4]) begin
      next_s.last_was_1 = 1'b0;
    end

    // Completion writes results back; they then hold until reloaded
    if (s.busy) begin
      if (done) begin
        next_s.busy = 1'b0;
        next_s.cnt  = 5'h00;
        next_s.data = s.res;
        ev[`MDSA_IRQ_DONE] = 1'b1;
        if (s.op == mdsa_pkg::MDSA_OP_NORM) begin
          next_s.sc = s.res_sc;
        end
        if (s.res_ovf) begin
          next_s.ovf = 1'b1;
          ev[`MDSA_IRQ_OVF] = 1'b1;
        end
      end else begin
        next_s.cnt = s.cnt - 5'h01;
      end
    end

    // Operand writes after the writeback so a same-cycle load is kept
    for (int k = 0; k < 6; k++) begin
      if (wr_data[k]) begin
        next_s.data[k] = apb_req.pwdata[7:0];
        next_s.seen[k] = 1'b1;
      end
    end

    // Data 0 write restarts the unit and clears the sequence tracking
    if (wr_data[0]) begin
      next_s.busy       = 1'b0;
      next_s.cnt        = 5'h00;
      next_s.op         = mdsa_pkg::MDSA_OP_NONE;
      next_s.seen       = 6'b000001;
      next_s.last_was_1 = 1'b0;
      next_s.ovf        = 1'b0;
    end

    if (start_div32 || start_div16 || start_mul || start_ctrl) begin
      next_s.busy = 1'b1;
      next_s.seen = 6'b000000;
      next_s.ovf  = 1'b0;
      next_s.res  = wd;
    end

    if (start_div32) begin
      next_s.op      = mdsa_pkg::MDSA_OP_DIV32;
      next_s.cnt     = `MDSA_LAT_DIV32;
      next_s.res     = {rem, quo};
      next_s.res_ovf = (opb == 16'h0000);
    end else if (start_div16) begin
      next_s.op      = mdsa_pkg::MDSA_OP_DIV16;
      next_s.cnt     = `MDSA_LAT_DIV16;
      next_s.res     = {rem16, wd[3], wd[2], quo16};
      next_s.res_ovf = (opb == 16'h0000);
    end else if (start_mul) begin
      next_s.op      = mdsa_pkg::MDSA_OP_MUL;
      next_s.cnt     = `MDSA_LAT_MUL;
      next_s.res     = {wd[5], wd[4], prod};
      next_s.res_ovf = (prod > `MDSA_MUL_LIMIT);
    end else if (start_ctrl) begin
      next_s.dir = apb_req.pwdata[`MDSA_CTRL_DIR];
      next_s.sc  = cnt_w;
      if (cnt_w == 5'h00) begin
        next_s.op      = mdsa_pkg::MDSA_OP_NORM;
        next_s.cnt     = `MDSA_LAT_NORM + 5'(({1'b0, lz} + 6'h01) >> 1);
        next_s.res     = {wd[5], wd[4], opa << lz};
        next_s.res_sc  = lz;
        next_s.res_ovf = opa[31];
      end else begin
        next_s.op      = mdsa_pkg::MDSA_OP_SHIFT;
        next_s.cnt     = `MDSA_LAT_SHIFT + 5'(({1'b0, cnt_w} + 6'h01) >> 1);
        next_s.res_ovf = 1'b0;
        if (apb_req.pwdata[`MDSA_CTRL_DIR]) begin
          next_s.res = {wd[5], wd[4], opa >> cnt_w};
        end else begin
          next_s.res = {wd[5], wd[4], opa << cnt_w};
        end
      end
    end

    // Error flag: a set in the same cycle as the clearing read wins
    next_s.err = (s.err && !(rd && idx == `MDSA_IDX_CTRL)) || set_err;
    if (set_err) begin
      ev[`MDSA_IRQ_ERR] = 1'b1;
    end

    if (wr && idx == `MDSA_IDX_IRQ_EN) begin
      next_s.irq_en = apb_req.pwdata[2:0];
    end
    if (wr && idx == `MDSA_IDX_IRQ_CLR) begin
      next_s.irq_sts = s.irq_sts & ~apb_req.pwdata[2:0];
    end
    next_s.irq_sts = next_s.irq_sts | ev;
    next_s.irq     = |(next_s.irq_sts & next_s.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.op         <= mdsa_pkg::MDSA_OP_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign irq     = s.irq;

endmodule

//--- bench/mdsa_apb_master.sv
/*
 * APB master standing in for the CPU core.
 * Assumes one wait-state slave; flags hung if pready never comes.
 */
module mdsa_apb_master (
  input  wire logic               pclk,
  input  wire logic [31:0]        prdata,
  input  wire logic               pready,
  input  wire logic               pslverr,
  output mdsa_pkg::mdsa_apb_req_s req,
  output logic                    hung
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req = '0;
    hung = 1'b0;
  end
  // Setup, then access held until pready
  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, {i, 2'b00}, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    hung = (n >= 40);
    req <= '0;
  endtask
endmodule

//--- bench/mdsa_accel_sva.sv
/*
 * Port checker of the accelerator.
 * Assumes single clock pclk and one wait-state APB.
 */
`include "mdsa_defs.svh"
module mdsa_accel_sva (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire mdsa_pkg::mdsa_apb_req_s apb_req,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] idx;
  logic       setup;
  logic       mapped;
  logic       ctrl_rd;
  assign idx = apb_req.paddr[11:2];
  assign setup = apb_req.psel && !apb_req.penable;
  assign mapped = idx >= `MDSA_IDX_DATA0 && idx <= `MDSA_IDX_IRQ_EN;
  assign ctrl_rd = pready && apb_req.psel && !apb_req.pwrite && idx == `MDSA_IDX_CTRL;
  sequence reread_s;
    ctrl_rd ##1 !apb_req.psel ##1 (setup && !apb_req.pwrite && idx == `MDSA_IDX_CTRL);
  endsequence
  a_one_wait: assert property (setup |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
  a_ready_access: assert property (pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (setup && !mapped |=> pslverr)
    else $error("no pslverr");
  a_mapped_ok: assert property (setup && mapped |=> !pslverr) else $error("bad pslverr");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
  a_byte_data: assert property (pready && idx < `MDSA_IDX_CTRL |-> prdata[31:8] == 24'h0)
    else $error("data wider than byte");
  a_err_cleared: assert property (reread_s |=> !prdata[`MDSA_CTRL_ERR])
    else $error("error flag kept");
endmodule
bind mdsa_accel mdsa_accel_sva chk_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

//--- bench/testbench.sv
/*
 * Register-level test of the accelerator.
 * Assumes the APB master model and the checker bound to the design.
 */
`include "mdsa_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  mdsa_pkg::mdsa_apb_req_s apb_req;
  logic [31:0]             prdata;
  logic [31:0]             q;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  logic                    hung;
  logic                    e;
  int                      num_errors = 0;
  int                      cmp_count = 0;
  always #25 pclk = ~pclk;
  mdsa_accel dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  mdsa_apb_master cpu_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req(apb_req), .hung(hung));
  task automatic conclude;
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hung) begin
    num_errors++;
    conclude();
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    cpu_u.xfer(1'b1, i, {24'h0, d}, q, e);
  endtask
  task automatic rd(input string nm, input logic [9:0] i, input logic [31:0] exp);
    cpu_u.xfer(1'b0, i, 32'h0, q, e);
    chk(nm, exp, q);
  endtask
  task automatic ld4(input logic [31:0] v);
    for (int k = 0; k < 4; k++) wr(10'(`MDSA_IDX_DATA0 + k), v[8*k+:8]);
  endtask
  task automatic rd32(input string nm, input logic [31:0] v);
    for (int k = 0; k < 4; k++) rd(nm, 10'(`MDSA_IDX_DATA0 + k), {24'h0, v[8*k+:8]});
  endtask
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  initial begin
    logic [15:0] dv;
    logic [31:0] r;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", `MDSA_IDX_CTRL, 32'h0);
    rd32("data", 32'h0);
    wr(`MDSA_IDX_DATA0, 8'h34);
    wr(`MDSA_IDX_DATA4, 8'h78);
    wr(`MDSA_IDX_DATA1, 8'h12);
    wr(`MDSA_IDX_DATA5, 8'h56);
    repeat (10) @(posedge pclk);
    rd32("product", 32'h1234 * 32'h5678);
    rd("mul ovf", `MDSA_IDX_CTRL, 32'h40);
    ld4(32'h1234_5678);
    wr(`MDSA_IDX_DATA4, 8'h00);
    wr(`MDSA_IDX_DATA5, 8'h01);
    repeat (17) @(posedge pclk);
    rd32("quot32", 32'h1234_5678 / 32'h100);
    rd("rem32", `MDSA_IDX_DATA4, 32'h78);
    rd("div ctrl", `MDSA_IDX_CTRL, 32'h0);
    $display("test mul and div32 done");
    for (int j = 0; j < 2; j++) begin
      dv = (j == 0) ? 16'h0010 : 16'h0000;
      wr(`MDSA_IDX_DATA0, 8'h34);
      wr(`MDSA_IDX_DATA1, 8'h12);
      wr(`MDSA_IDX_DATA4, dv[7:0]);
      wr(`MDSA_IDX_DATA5, dv[15:8]);
      repeat (9) @(posedge pclk);
      rd("ovf16", `MDSA_IDX_CTRL, (j == 0) ? 32'h0 : 32'h40);
      if (j == 0) begin
        rd("quot16", `MDSA_IDX_DATA0, 32'h23);
        rd("rem16", `MDSA_IDX_DATA4, 32'h04);
      end
    end
    ld4(32'h0000_1000);
    wr(`MDSA_IDX_CTRL, 8'h00);
    repeat (20) @(posedge pclk);
    rd32("norm", 32'h8000_0000);
    rd("norm cnt", `MDSA_IDX_CTRL, 32'h13);
    wr(`MDSA_IDX_CTRL, 8'h00);
    repeat (20) @(posedge pclk);
    rd("norm ovf", `MDSA_IDX_CTRL, 32'h40);
    for (int j = 0; j < 4; j++) begin
      ld4(32'h00f0_000f);
      wr(`MDSA_IDX_CTRL, {2'b00, j[0], j[1] ? 5'h1f : 5'h01});
      repeat (18) @(posedge pclk);
      r = j[0] ? 32'h00f0_000f >> (j[1] ? 31 : 1) : 32'h00f0_000f << (j[1] ? 31 : 1);
      rd32("shift", r);
    end
    $display("test norm and shift done");
    wr(`MDSA_IDX_DATA0, 8'h02);
    wr(`MDSA_IDX_DATA4, 8'h03);
    wr(`MDSA_IDX_DATA1, 8'h00);
    wr(`MDSA_IDX_DATA5, 8'h00);
    wr(`MDSA_IDX_DATA1, 8'h00);
    cpu_u.xfer(1'b0, `MDSA_IDX_CTRL, 32'h0, q, e);
    chk("err set", 32'h80, q & 32'h80);
    cpu_u.xfer(1'b0, `MDSA_IDX_CTRL, 32'h0, q, e);
    chk("err clr", 32'h0, q & 32'h80);
    wr(`MDSA_IDX_IRQ_CLR, 8'h07);
    wr(`MDSA_IDX_IRQ_EN, 8'h01);
    chk_irq(1'b0);
    wr(`MDSA_IDX_CTRL, 8'h02);
    repeat (18) @(posedge pclk);
    chk_irq(1'b1);
    rd("irq sts", `MDSA_IDX_IRQ_STS, 32'h1);
    wr(`MDSA_IDX_IRQ_EN, 8'h00);
    chk_irq(1'b0);
    wr(`MDSA_IDX_IRQ_EN, 8'h01);
    chk_irq(1'b1);
    wr(`MDSA_IDX_IRQ_CLR, 8'h01);
    chk_irq(1'b0);
    rd("unmapped", 10'h103, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    $display("test error and irq done");
    conclude();
  end
endmodule
